//--- rtl/icc_checker.sv
// Purpose: Classify fetched words and check load/store operand conventions
// Assumes: All inputs come from logic on core_clk, one word per cycle
// Notes: One cycle latency; exception request is a single-cycle pulse
// Notes on behaviour
// [RQ1] Class from primary plus extended opcode
// [RQ2] Listed unused primaries are illegal, trap
// [RQ3] 64-bit-only primaries illegal here, trap
// [RQ4] Unassigned extended opcodes are illegal
// [RQ5] 64-bit-only extended opcodes are illegal
// [RQ6] All-zero word is illegal, trap
// [RQ7] Zero primary, nonzero word is reserved
// [RQ8] Unimplemented reserved instruction traps
// [RQ9] Square roots and tlb-invalidate-all trap
// [RQ10] Traps use program vector 0x00700
// [RQ11] Bad reserved bits never raise privilege
// [RQ12] Instructions are aligned four-byte words
// [RQ13] Load/store sizes and 32-entry register sets
// [RQ14] Integer word, float single/double operands
// [RQ15] Arithmetic and logic never touch memory
// [RQ16] Byte addressed, operand at lowest byte
// [RQ17] Big-endian unless little-endian selected
// [RQ18] Aligned only at multiple of length
// [RQ19] Class and one-cycle trap pulse output
`timescale 1ns/1ps
module icc_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire icc_pkg::icc_fetch_t fetch,
  input wire icc_pkg::icc_chk_req_t chk_req,
  input wire logic le_mode,
  output icc_pkg::icc_rsp_t rsp,
  output icc_pkg::icc_chk_rsp_t chk_rsp
);
  // Fields of the incoming word
  logic [5:0] prim;
  logic [9:0] xo;
  assign prim = fetch.word[31:26];
  assign xo = fetch.word[10:1];

  // Integer group, X and XO forms defined for 32-bit parts
  function automatic logic ext31_ok(input logic [9:0] x);
    logic r;
    r = 1'b0;
    case (x)
      10'h000, 10'h004, 10'h00b, 10'h013, 10'h014, 10'h017, 10'h018, 10'h01a, 10'h01c,
      10'h020, 10'h036, 10'h037, 10'h03c, 10'h04b, 10'h053, 10'h056, 10'h057, 10'h077,
      10'h07c, 10'h090, 10'h092, 10'h096, 10'h097, 10'h0b7, 10'h0d2, 10'h0d7, 10'h0f2,
      10'h0f6, 10'h0f7, 10'h116, 10'h117, 10'h11c, 10'h132, 10'h136, 10'h137, 10'h13c,
      10'h153, 10'h157, 10'h173, 10'h177, 10'h197, 10'h19c, 10'h1b6, 10'h1b7, 10'h1bc,
      10'h1d3, 10'h1d6, 10'h1dc, 10'h200, 10'h215, 10'h216, 10'h217, 10'h218, 10'h236,
      10'h237, 10'h253, 10'h255, 10'h256, 10'h257, 10'h277, 10'h293, 10'h295, 10'h296,
      10'h297, 10'h2b7, 10'h2d5, 10'h2d7, 10'h2f7, 10'h316, 10'h318, 10'h338, 10'h356,
      10'h396, 10'h39a, 10'h3ba, 10'h3d6, 10'h3d7, 10'h3f6: r = 1'b1;
      default: r = 1'b0; // see [RQ4] [RQ5]
    endcase
    // XO form ignores the overflow-enable bit
    case (x[8:0])
      9'h008, 9'h00a, 9'h028, 9'h068, 9'h088, 9'h08a, 9'h0c8, 9'h0ca, 9'h0e8, 9'h0ea,
      9'h0eb, 9'h10a, 9'h1cb, 9'h1eb: r = 1'b1;
      default: r = r;
    endcase
    return r;
  endfunction

  // Condition register and branch group
  function automatic logic ext19_ok(input logic [9:0] x);
    case (x)
      10'h000, 10'h010, 10'h021, 10'h032, 10'h081, 10'h096, 10'h0c1, 10'h0e1, 10'h101,
      10'h121, 10'h1a1, 10'h1c1, 10'h210: return 1'b1;
      default: return 1'b0; // see [RQ4]
    endcase
  endfunction

  // Float A form; double group adds select and reciprocal root estimate
  function automatic logic fa_ok(input logic [4:0] x, input logic dbl);
    case (x)
      5'h12, 5'h14, 5'h15, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f: return 1'b1;
      5'h18: return !dbl;
      5'h17, 5'h1a: return dbl;
      default: return 1'b0; // see [RQ4]
    endcase
  endfunction

  // Float X form, double group only
  function automatic logic fx_ok(input logic [9:0] x);
    case (x)
      10'h000, 10'h00c, 10'h00e, 10'h00f, 10'h020, 10'h026, 10'h028, 10'h040, 10'h046,
      10'h048, 10'h086, 10'h088, 10'h108, 10'h247, 10'h2c7: return 1'b1;
      default: return 1'b0; // see [RQ4] [RQ5]
    endcase
  endfunction

  // Combinational classification of the current word
  icc_pkg::icc_class_t next_class;
  icc_pkg::icc_cause_t next_cause;
  logic opt_unimpl;
  logic ls_op;
  logic fetch_misaligned;

  // Optional instructions left to software emulation
  always_comb
  begin
    opt_unimpl = 1'b0;
    if ((prim == icc_pkg::ICC_OP_FPS || prim == icc_pkg::ICC_OP_FPD) && xo[4:0] == 5'h16)
    begin
      opt_unimpl = 1'b1; // see [RQ9]
    end
    else if (prim == icc_pkg::ICC_OP_INT && xo == 10'h172)
    begin
      opt_unimpl = 1'b1; // see [RQ9]
    end
  end

  // Word must sit on a four-byte boundary
  assign fetch_misaligned = (fetch.addr[1:0] != 2'h0); // see [RQ12]
  assign ls_op = (prim >= icc_pkg::ICC_OP_LS_LO) && (prim <= icc_pkg::ICC_OP_LS_HI);

  // Class from primary opcode, then extended opcode where one exists
  always_comb
  begin
    next_class = icc_pkg::ICC_ILLEGAL; // see [RQ1]
    case (prim)
      6'h00:
        // Zero word illegal, other zero-primary words reserved
        if (fetch.word == 32'h0000_0000)
          next_class = icc_pkg::ICC_ILLEGAL; // see [RQ6]
        else
          next_class = icc_pkg::ICC_RESERVED; // see [RQ7]
      6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16, 6'h38, 6'h39, 6'h3c, 6'h3d:
        next_class = icc_pkg::ICC_ILLEGAL; // see [RQ2]
      6'h02, 6'h1e, 6'h3a, 6'h3e:
        next_class = icc_pkg::ICC_ILLEGAL; // see [RQ3]
      6'h03, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h12, 6'h14,
      6'h15, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d:
        next_class = icc_pkg::ICC_DEFINED;
      icc_pkg::ICC_OP_SC:
        // System call needs its fixed one bit set
        next_class = fetch.word[1] ? icc_pkg::ICC_DEFINED : icc_pkg::ICC_ILLEGAL;
      icc_pkg::ICC_OP_CR:
        next_class = ext19_ok(xo) ? icc_pkg::ICC_DEFINED : icc_pkg::ICC_ILLEGAL;
      icc_pkg::ICC_OP_INT:
        next_class = (ext31_ok(xo) || opt_unimpl) ? icc_pkg::ICC_DEFINED : icc_pkg::ICC_ILLEGAL;
      icc_pkg::ICC_OP_FPS:
        next_class = (fa_ok(xo[4:0], 1'b0) || opt_unimpl) ? icc_pkg::ICC_DEFINED :
                     icc_pkg::ICC_ILLEGAL;
      icc_pkg::ICC_OP_FPD:
        // A form when bit 4 of the five-bit low XO field is set, else X form
        if (xo[4])
          next_class = (fa_ok(xo[4:0], 1'b1) || opt_unimpl) ? icc_pkg::ICC_DEFINED :
                       icc_pkg::ICC_ILLEGAL;
        else
          next_class = fx_ok(xo) ? icc_pkg::ICC_DEFINED : icc_pkg::ICC_ILLEGAL;
      default:
        // Remaining primaries are the load/store range
        next_class = ls_op ? icc_pkg::ICC_DEFINED : icc_pkg::ICC_ILLEGAL;
    endcase
  end

  // Cause priority: fetch alignment, then class, then optional
  always_comb
  begin
    next_cause = icc_pkg::ICC_CAUSE_NONE;
    if (fetch_misaligned)
      next_cause = icc_pkg::ICC_CAUSE_FETCH_ALIGN; // see [RQ12]
    else if (next_class == icc_pkg::ICC_ILLEGAL)
      next_cause = icc_pkg::ICC_CAUSE_ILLEGAL; // see [RQ2] [RQ3] [RQ6]
    else if (next_class == icc_pkg::ICC_RESERVED)
      // No reserved instruction is implemented, so all of them trap
      next_cause = icc_pkg::ICC_CAUSE_RSVD_UNIMPL; // see [RQ8]
    else if (opt_unimpl)
      next_cause = icc_pkg::ICC_CAUSE_OPT_UNIMPL; // see [RQ9]
  end

  // Decode answer register; the pulse lasts only one cycle per word
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp.valid <= fetch.valid; // see [RQ19]
      rsp.iclass <= next_class;
      rsp.exc_req <= fetch.valid && (next_cause != icc_pkg::ICC_CAUSE_NONE); // see [RQ19]
      rsp.cause <= fetch.valid ? next_cause : icc_pkg::ICC_CAUSE_NONE;
      rsp.vector <= icc_pkg::ICC_PROG_VECTOR; // see [RQ10]
      // Memory access only for load/store class, never arithmetic
      rsp.is_mem <= ls_op && next_cause == icc_pkg::ICC_CAUSE_NONE; // see [RQ15]
      rsp.is_float <= ls_op && prim[4]; // see [RQ13]
      rsp.is_store <= ls_op && (prim[4] ? prim[2] : (prim[2] || prim[3:1] == 3'h7));
      rsp.reg_idx <= fetch.word[25:21]; // see [RQ13]
      // Operand length: word for non-memory ops, byte/half/word for integer loads/stores, word/double for float
      if (!ls_op)
        rsp.size <= icc_pkg::ICC_SZ_WORD; // see [RQ14]
      else if (prim[4])
        rsp.size <= prim[1] ? icc_pkg::ICC_SZ_DBL : icc_pkg::ICC_SZ_WORD; // see [RQ14]
      else if (prim[3])
        rsp.size <= (prim[2:1] == 2'h3) ? icc_pkg::ICC_SZ_WORD : icc_pkg::ICC_SZ_HALF;
      else
        rsp.size <= prim[1] ? icc_pkg::ICC_SZ_BYTE : icc_pkg::ICC_SZ_WORD; // see [RQ13]
    end
  end
  // Reserved-bit misuse only yields class and cause; nothing here drives privilege. see [RQ11]

  // Operand alignment, byte numbering and byte order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      chk_rsp <= '0;
    end
    else
    begin
      chk_rsp.valid <= chk_req.valid;
      // Natural boundary: low address bits under the length are zero
      chk_rsp.misaligned <= chk_req.valid &&
                            ((chk_req.ea & ({28'h0, chk_req.size} - 32'h1)) != 32'h0); // see [RQ18]
      chk_rsp.big_endian <= !le_mode; // see [RQ17]
      chk_rsp.first_byte <= chk_req.ea; // see [RQ16]
    end
  end

  // Checks on the registered answers
  default clocking icc_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_zero_word;
    fetch.valid && fetch.word == 32'h0 && fetch.addr[1:0] == 2'h0
      |=> rsp.exc_req && rsp.iclass == icc_pkg::ICC_ILLEGAL;
  endproperty
  a_zero_word: assert property (p_zero_word) else $error("Zero word not trapped"); // see [RQ6]

  property p_rsvd;
    fetch.valid && prim == 6'h00 && fetch.word != 32'h0
      |=> rsp.iclass == icc_pkg::ICC_RESERVED && rsp.exc_req;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved word misclassed"); // see [RQ7] [RQ8]

  property p_unused_prim;
    fetch.valid && (prim == 6'h16 || prim == 6'h39 || prim == 6'h01)
      |=> rsp.iclass == icc_pkg::ICC_ILLEGAL && rsp.exc_req;
  endproperty
  a_unused_prim: assert property (p_unused_prim) else $error("Unused primary passed"); // see [RQ2]

  property p_wide_prim;
    fetch.valid && (prim == 6'h1e || prim == 6'h3e) |=> rsp.iclass == icc_pkg::ICC_ILLEGAL;
  endproperty
  a_wide_prim: assert property (p_wide_prim) else $error("64-bit primary passed"); // see [RQ3]

  property p_vector;
    rsp.exc_req |-> rsp.valid && rsp.vector == 20'h00700 && rsp.cause != 3'h0;
  endproperty
  a_vector: assert property (p_vector) else $error("Trap without vector"); // see [RQ10] [RQ19]

  property p_fetch_align;
    fetch.valid && fetch.addr[1:0] != 2'h0 |=> rsp.exc_req ##1 !rsp.exc_req || $past(fetch.valid);
  endproperty
  a_fetch_align: assert property (p_fetch_align) else $error("Misaligned fetch ok"); // see [RQ12]

  property p_sqrt;
    fetch.valid && prim == 6'h3f && xo[4:0] == 5'h16 |=> rsp.exc_req && rsp.cause != 3'h0;
  endproperty
  a_sqrt: assert property (p_sqrt) else $error("Square root not trapped"); // see [RQ9]

  property p_align;
    chk_req.valid && chk_req.size == 4'h4 && chk_req.ea[1:0] != 2'h0 |=> chk_rsp.misaligned;
  endproperty
  a_align: assert property (p_align) else $error("Misaligned word missed"); // see [RQ18]

  property p_order;
    !le_mode ##1 !le_mode |-> chk_rsp.big_endian;
  endproperty
  a_order: assert property (p_order) else $error("Byte order not big"); // see [RQ17]

  property p_ext;
    fetch.valid && prim == 6'h1f && xo == 10'h01b |=> rsp.iclass == icc_pkg::ICC_ILLEGAL;
  endproperty
  a_ext: assert property (p_ext) else $error("64-bit extended passed"); // see [RQ5]

  // A trapped word must never go on to start a memory access
  property p_trap_no_mem;
    rsp.exc_req |-> !rsp.is_mem;
  endproperty
  a_trap_no_mem: assert property (p_trap_no_mem) else $error("Trap starts access"); // see [RQ11]

  // Only the load/store primary range may reach memory
  property p_no_mem;
    fetch.valid && !(prim >= 6'h20 && prim <= 6'h37) |=> !rsp.is_mem && rsp.size == 4'h4;
  endproperty
  a_no_mem: assert property (p_no_mem) else $error("Arith uses memory"); // see [RQ15]

  // Float loads and stores go to the float register set
  property p_ls_float;
    fetch.valid && prim >= 6'h30 && prim <= 6'h37 && fetch.addr[1:0] == 2'h0
      |=> rsp.is_mem && rsp.is_float;
  endproperty
  a_ls_float: assert property (p_ls_float) else $error("Float access missed"); // see [RQ13]

  // Operand address is passed on unchanged as its lowest byte
  property p_first_byte;
    chk_req.valid |=> chk_rsp.valid && chk_rsp.first_byte == $past(chk_req.ea);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("Operand address lost"); // see [RQ16]

  // Any multiple of eight is aligned for every legal length
  property p_nat_align;
    chk_req.valid && chk_req.size != 4'h0 && chk_req.size <= 4'h8 && chk_req.ea[2:0] == 3'h0
      |=> !chk_rsp.misaligned;
  endproperty
  a_nat_align: assert property (p_nat_align) else $error("Aligned operand flagged"); // see [RQ18]

  // No answer and no trap without a word behind it
  property p_idle;
    !fetch.valid |=> !rsp.valid && !rsp.exc_req;
  endproperty
  a_idle: assert property (p_idle) else $error("Answer without word"); // see [RQ19]

  // Main scenarios
  c_illegal: cover property (rsp.exc_req && rsp.cause == icc_pkg::ICC_CAUSE_ILLEGAL);
  c_reserved: cover property (rsp.valid && rsp.iclass == icc_pkg::ICC_RESERVED);
  c_load: cover property (rsp.valid && rsp.is_mem && !rsp.is_store);
  c_misalign: cover property (chk_rsp.misaligned);
  c_fetch_align: cover property (rsp.exc_req && rsp.cause == icc_pkg::ICC_CAUSE_FETCH_ALIGN);
endmodule // icc_checker

//--- rtl/icc_pkg.sv
// Purpose: Shared constants and carriers for the instruction class checker
// Assumes: 32-bit instruction words, primary opcode in word[31:26]
// Notes: Opcode values are architectural encodings, not tunables
package icc_pkg;
  // Instruction class seen by the pipeline
  typedef enum logic [1:0] {
    ICC_DEFINED = 2'h0,
    ICC_RESERVED = 2'h1,
    ICC_ILLEGAL = 2'h2
  } icc_class_t;
  // Why the exception was requested
  typedef enum logic [2:0] {
    ICC_CAUSE_NONE = 3'h0,
    ICC_CAUSE_ILLEGAL = 3'h1,
    ICC_CAUSE_RSVD_UNIMPL = 3'h2,
    ICC_CAUSE_OPT_UNIMPL = 3'h3,
    ICC_CAUSE_FETCH_ALIGN = 3'h4
  } icc_cause_t;
  // Program exception vector offset
  localparam logic [19:0] ICC_PROG_VECTOR = 20'h00700;
  // Instruction length in bytes and register set depth
  localparam logic [3:0] ICC_INSN_BYTES = 4'h4;
  localparam int ICC_REG_COUNT = 32;
  // Operand size codes, value is the length in bytes
  localparam logic [3:0] ICC_SZ_BYTE = 4'h1;
  localparam logic [3:0] ICC_SZ_HALF = 4'h2;
  localparam logic [3:0] ICC_SZ_WORD = 4'h4;
  localparam logic [3:0] ICC_SZ_DBL = 4'h8;
  // Primary opcodes decoded further, by extended opcode or, for sc, by word[1]
  localparam logic [5:0] ICC_OP_SC = 6'h11;
  localparam logic [5:0] ICC_OP_CR = 6'h13;
  localparam logic [5:0] ICC_OP_INT = 6'h1f;
  localparam logic [5:0] ICC_OP_FPS = 6'h3b;
  localparam logic [5:0] ICC_OP_FPD = 6'h3f;
  // Load/store primary opcode range
  localparam logic [5:0] ICC_OP_LS_LO = 6'h20;
  localparam logic [5:0] ICC_OP_LS_HI = 6'h37;
  // Fetch request from the fetch unit
  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [31:0] addr;
  } icc_fetch_t;
  // Decode answer toward pipeline and exception unit
  typedef struct packed {
    logic valid;
    icc_class_t iclass;
    logic exc_req;
    icc_cause_t cause;
    logic [19:0] vector;
    logic is_mem;
    logic is_float;
    logic is_store;
    logic [3:0] size;
    logic [4:0] reg_idx;
  } icc_rsp_t;
  // Operand alignment check request
  typedef struct packed {
    logic valid;
    logic [31:0] ea;
    logic [3:0] size;
  } icc_chk_req_t;
  // Operand alignment check answer
  typedef struct packed {
    logic valid;
    logic misaligned;
    logic big_endian;
    logic [31:0] first_byte;
  } icc_chk_rsp_t;
endpackage

//--- test/icc_fetch_model.sv
// Purpose: Fetch unit stand-in presenting words to the checker
// Assumes: Tasks are entered just after a rising core_clk edge
// Notes: Released lines show the inverse of the last word, never a stale copy
`timescale 1ns/1ps
module icc_fetch_model (
  output icc_pkg::icc_fetch_t fetch
);
  // Idle at time zero
  initial fetch = '0;
  // Present one word, held until released after the taking edge
  task automatic put(input logic [31:0] word, input logic [31:0] addr);
    fetch.valid = 1'b1;
    fetch.word = word;
    fetch.addr = addr;
  endtask
  // Drop valid and scramble the lines so nothing stale can pass
  task automatic drop();
    fetch.valid = 1'b0;
    fetch.word = ~fetch.word;
    fetch.addr = ~fetch.addr;
  endtask
endmodule // icc_fetch_model

//--- test/icc_checker_tb.sv
// Purpose: Self-checking bench for the instruction class checker
// Assumes: One-cycle answer, single-cycle trap pulse, no back-pressure
// Notes: Inputs move 1 ns after the rising edge; outputs read 2 ns after
`timescale 1ns/1ps
module icc_checker_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic le_mode = 1'b0;
  icc_pkg::icc_fetch_t fetch;
  icc_pkg::icc_chk_req_t chk_req = '0;
  icc_pkg::icc_rsp_t rsp;
  icc_pkg::icc_chk_rsp_t chk_rsp;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Word stream source
  icc_fetch_model fm (
    .fetch(fetch)
  );
  icc_checker dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fetch(fetch),
    .chk_req(chk_req),
    .le_mode(le_mode),
    .rsp(rsp),
    .chk_rsp(chk_rsp)
  );
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  // Shared compare, counts every sample
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Word with rd=3, rb=5 and the extended opcode in [10:1]
  function automatic logic [31:0] enc(input logic [5:0] op, input logic [9:0] xo);
    return {op, 5'h03, 5'h00, 5'h05, xo, 1'h0};
  endfunction
  // One word through decode; mem is {is_mem, is_float, is_store, size}
  task automatic dec(input logic [31:0] w, input logic [31:0] a, input logic [1:0] cls,
    input logic [2:0] cause, input logic [6:0] mem);
    fm.put(w, a);
    @(posedge core_clk);
    #1 fm.drop();
    #1 chk("rsp.valid", 32'h1, rsp.valid);
    chk("rsp.iclass", cls, rsp.iclass);
    chk("rsp.cause", cause, rsp.cause);
    chk("rsp.exc_req", cause != 3'h0, rsp.exc_req);
    chk("rsp.vector", 32'h00700, rsp.vector);
    chk("rsp.mem", mem, {rsp.is_mem, rsp.is_float, rsp.is_store, rsp.size});
    chk("rsp.reg_idx", w[25:21], rsp.reg_idx);
    @(posedge core_clk);
    #1 chk("exc_req pulse", 32'h0, rsp.exc_req);
  endtask
  // All-zero word traps; zero primary with other bits set is reserved
  task automatic t_zero();
    dec(32'h0, 32'h100, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h00, 10'h000), 32'h104, 2'h1, 3'h2, 7'h04);
    $display("test zero done");
  endtask
  // Unused and 64-bit-only primary opcodes
  task automatic t_prim();
    logic [5:0] ops [14] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16, 6'h38,
      6'h39, 6'h3c, 6'h3d, 6'h02, 6'h1e, 6'h3a, 6'h3e};
    foreach (ops[i])
      dec(enc(ops[i], 10'h000), 32'h200, 2'h2, 3'h1, 7'h04);
    $display("test primaries done");
  endtask
  // Extended opcodes: assigned, unassigned, 64-bit-only, optional
  task automatic t_ext();
    // Defined: addi, add, mcrf, sc with word[1] set
    dec(enc(6'h0e, 10'h000), 32'h300, 2'h0, 3'h0, 7'h04);
    dec(enc(6'h1f, 10'h10a), 32'h304, 2'h0, 3'h0, 7'h04);
    dec(enc(6'h13, 10'h000), 32'h308, 2'h0, 3'h0, 7'h04);
    dec(enc(6'h11, 10'h001), 32'h30c, 2'h0, 3'h0, 7'h04);
    // Unassigned extended opcodes, and sc with word[1] clear
    dec(enc(6'h11, 10'h000), 32'h310, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h13, 10'h001), 32'h314, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h3f, 10'h002), 32'h318, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h3b, 10'h002), 32'h31c, 2'h2, 3'h1, 7'h04);
    // Extended opcodes of the 64-bit machine only
    dec(enc(6'h1f, 10'h03a), 32'h320, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h1f, 10'h015), 32'h324, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h1f, 10'h01b), 32'h33c, 2'h2, 3'h1, 7'h04);
    dec(enc(6'h3f, 10'h32e), 32'h328, 2'h2, 3'h1, 7'h04);
    // Optional square roots and translation flush trap for emulation
    dec(enc(6'h3f, 10'h016), 32'h32c, 2'h0, 3'h3, 7'h04);
    dec(enc(6'h3b, 10'h016), 32'h330, 2'h0, 3'h3, 7'h04);
    dec(enc(6'h1f, 10'h172), 32'h334, 2'h0, 3'h3, 7'h04);
    $display("test extended done");
  endtask
  // Load/store decode: size, float set, direction; misaligned fetch
  task automatic t_ldst();
    logic [5:0] ops [8] = '{6'h20, 6'h22, 6'h28, 6'h26, 6'h2c, 6'h30, 6'h32, 6'h36};
    logic [6:0] mem [8] = '{7'h44, 7'h41, 7'h42, 7'h51, 7'h52, 7'h64, 7'h68, 7'h78};
    foreach (ops[i])
      dec(enc(ops[i], 10'h000), 32'h400, 2'h0, 3'h0, mem[i]);
    dec(enc(6'h0e, 10'h000), 32'h402, 2'h0, 3'h4, 7'h04);
    // A trapped load must not be handed on as a memory access
    dec(enc(6'h20, 10'h000), 32'h401, 2'h0, 3'h4, 7'h04);
    $display("test load store done");
  endtask
  // Natural alignment, first byte address and byte order
  task automatic t_align();
    logic [31:0] ea [8] = '{32'h0, 32'h3, 32'h2, 32'h1, 32'h4, 32'h2, 32'h8, 32'h4};
    logic [3:0] sz [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
    logic mis [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    foreach (ea[i])
    begin
      chk_req = '{1'b1, ea[i], sz[i]};
      le_mode = i[0];
      @(posedge core_clk);
      // Scramble released lines so a stale value cannot match
      #1 chk_req = '{1'b0, ~ea[i], ~sz[i]};
      #1 chk("chk_rsp.valid", 32'h1, chk_rsp.valid);
      chk("misaligned", mis[i], chk_rsp.misaligned);
      chk("first_byte", ea[i], chk_rsp.first_byte);
      chk("big_endian", !i[0], chk_rsp.big_endian);
      @(posedge core_clk);
      #1;
    end
    $display("test align done");
  endtask
  // Mid-run reset clears the answer, vector returns once released
  task automatic t_reset();
    fm.put(32'h0, 32'h500);
    rst_n = 1'b0;
    @(posedge core_clk);
    #1 fm.drop();
    #1 chk("reset rsp", 32'h0, {rsp.valid, rsp.exc_req, rsp.vector});
    @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1 chk("vector after reset", 32'h00700, rsp.vector);
    $display("test reset done");
  endtask
  // Verdict, the single exit of the run
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence after a 12-cycle reset
  initial
  begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1 t_zero();
    t_prim();
    t_ext();
    t_ldst();
    t_align();
    t_reset();
    final_report();
  end
  // Watchdog: the tests need about 115 cycles
  initial
  begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
endmodule // icc_checker_tb
